/* core/fifo_port_control_defines.svh */
// constants for the buffer port control block
`ifndef FIFO_PORT_CONTROL_DEFINES_SVH
`define FIFO_PORT_CONTROL_DEFINES_SVH
`define DATA_W        36
`define CFG_W         8
`define BUF_DEPTH     16
`define BUF_AW        4
`define PTR_W         5
`define HALF_LEVEL    5'h08
`define FULL_LEVEL    5'h10
`define STAGE_DEPTH   8
`define WIDTH_SEL_RST 3'h7
`define CFG_RST       8'h00
`endif

/* core/fifo_port_control_pkg.sv */
// types for the buffer port control block
package fifo_port_control_pkg;
    typedef enum logic [1:0] {
        src_buffer  = 2'b00,
        src_config  = 2'b01,
        src_mailbox = 2'b10
    } read_source_type;
endpackage

/* core/port_memory.sv */
// small buffer memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module port_memory #(
    parameter int WIDTH = 36,
    parameter int AW    = 4
) (
    input  wire logic             clk,
    input  wire logic             write_en,
    input  wire logic [AW-1:0]    write_addr,
    input  wire logic [WIDTH-1:0] write_data,
    input  wire logic             read_en,
    input  wire logic [AW-1:0]    read_addr,
    output logic      [WIDTH-1:0] read_data
);
    logic [WIDTH-1:0] cells [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (write_en) begin
            cells[write_addr] <= write_data;
        end
    end

    always_ff @(posedge clk) begin
        if (read_en) begin
            read_data <= cells[read_addr];
        end
    end
endmodule
`default_nettype wire

/* core/stage_fifo.sv */
// staging fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module stage_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] slots [0:DEPTH-1];
    logic [AW-1:0]    head;
    logic [AW-1:0]    tail;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = slots[head];

    always_ff @(posedge clk) begin
        if (push) begin
            slots[tail] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            head  <= '0;
            tail  <= '0;
            count <= '0;
        end else if (flush) begin
            head  <= '0;
            tail  <= '0;
            count <= '0;
        end else begin
            if (push) begin
                tail <= tail + 1'b1;
            end
            if (pop) begin
                head <= head + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* core/fifo_port_control.sv */
// port control of a programmable first-in first-out buffer
//
// How it works
// [RULE1] full clear zeroes pointers, flags, output, config
// [RULE2] partial clear keeps configuration, zeroes the rest
// [RULE3] one width select serves both ports
// [RULE4] write strobe low accepts word each edge
// [RULE5] config path uses low byte only
// [RULE6] pointer advances; gate off masks the write
// [RULE7] read strobe fetches next word from source
// [RULE8] output enable low drives data pins
// [RULE9] valid strobe low while output is valid; here it is low one cycle per new word
// [RULE10] mark records location of shown word
// [RULE11] replay pulse reloads read pointer from mark
// [RULE12] replay repeats words in order until empty
// [RULE13] mailbox select routes through one register
// [RULE14] empty and full flags are active low
// [RULE15] half level flag low at half occupancy
// [RULE16] mark, replay, mailbox are active high
// [RULE17] read while empty holds pointer, no valid
`timescale 1ns/100ps
`default_nettype none
`include "fifo_port_control_defines.svh"
module fifo_port_control (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                full_clear_n,
    input  wire logic                partial_clear_n,
    input  wire logic [2:0]          word_width_sel,
    input  wire logic                config_path_sel,
    input  wire logic                write_n,
    input  wire logic                input_gate_n,
    input  wire logic [`DATA_W-1:0]  data_in,
    input  wire logic                read_n,
    input  wire logic                output_enable_n,
    input  wire logic                mark,
    input  wire logic                replay_strobe,
    input  wire logic                mailbox_select,
    output logic      [`DATA_W-1:0]  data_out,
    output logic      [`DATA_W-1:0]  data_out_en,
    output logic                     output_valid_n,
    output logic                     empty_n,
    output logic                     full_n,
    output logic                     half_level_n,
    output logic      [2:0]          active_width,
    output logic                     stage_ready
);
    // ****************************************
    // reset and pin synchronisers
    // ****************************************
    logic       rst_meta;
    logic       rst_sync;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // control pins come from another domain; data is sampled alongside
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            pin_meta <= 8'hff;
            pin_sync <= 8'hff;
        end else begin
            pin_meta <= {full_clear_n, partial_clear_n, write_n, read_n,
                         ~mark, ~replay_strobe, ~mailbox_select, config_path_sel};
            pin_sync <= pin_meta;
        end
    end

    logic full_clear;
    logic part_clear;
    logic wr_req;
    logic rd_req;
    logic mark_s;
    logic replay_s;
    logic mbox_s;
    logic buf_path;
    // [RULE16] active high strobes
    assign full_clear = ~pin_sync[7];
    assign part_clear = ~pin_sync[6];
    assign wr_req     = ~pin_sync[5];
    assign rd_req     = ~pin_sync[4];
    assign mark_s     = ~pin_sync[3];
    assign replay_s   = ~pin_sync[2];
    assign mbox_s     = ~pin_sync[1];
    assign buf_path   = pin_sync[0];

    logic [`DATA_W-1:0] din_meta;
    logic [`DATA_W-1:0] din_sync;
    logic [1:0]         gate_meta;
    logic [1:0]         gate_sync;
    logic [2:0]         width_meta;
    logic [2:0]         width_sync;

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            din_meta   <= '0;
            din_sync   <= '0;
            gate_meta  <= 2'h3;
            gate_sync  <= 2'h3;
            width_meta <= `WIDTH_SEL_RST;
            width_sync <= `WIDTH_SEL_RST;
        end else begin
            din_meta   <= data_in;
            din_sync   <= din_meta;
            gate_meta  <= {input_gate_n, output_enable_n};
            gate_sync  <= gate_meta;
            width_meta <= word_width_sel;
            width_sync <= width_meta;
        end
    end

    logic any_clear;
    assign any_clear = full_clear || part_clear;

    // ****************************************
    // configuration and width
    // ****************************************
    logic [`CFG_W-1:0] config_reg;
    logic              wr_fire;

    // [RULE4] one accepted word per edge while strobe low
    assign wr_fire = wr_req && !mbox_s;

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            config_reg   <= `CFG_RST;
        end else if (full_clear) begin
            // [RULE1] defaults restored
            config_reg   <= `CFG_RST;
        end else if (!part_clear && wr_fire && !buf_path && !gate_sync[1]) begin
            // [RULE5] low byte only; [RULE2] kept across partial clear
            config_reg   <= din_sync[`CFG_W-1:0];
        end
    end

    // [RULE3] single width for both ports, held by the host
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            active_width <= `WIDTH_SEL_RST;
        end else begin
            active_width <= width_sync;
        end
    end

    // ****************************************
    // staging fifo in the write path
    // ****************************************
    logic               stg_valid;
    logic               stg_pop;
    logic [`DATA_W:0]   stg_data;
    logic               stg_push;

    // masked words still travel so the pointer advances
    assign stg_push = wr_fire && buf_path && !any_clear;

    stage_fifo #(
        .WIDTH (`DATA_W + 1),
        .DEPTH (`STAGE_DEPTH)
    ) u_stage (
        .clk       (clk),
        .rst_b     (rst_sync),
        .flush     (any_clear),
        .in_valid  (stg_push),
        .in_ready  (stage_ready),
        .in_data   ({gate_sync[1], din_sync}),
        .out_valid (stg_valid),
        .out_ready (stg_pop),
        .out_data  (stg_data)
    );

    // ****************************************
    // buffer pointers and flags
    // ****************************************
    logic [`PTR_W-1:0] wr_ptr;
    logic [`PTR_W-1:0] rd_ptr;
    logic [`PTR_W-1:0] mark_ptr;
    logic [`PTR_W-1:0] shown_ptr;
    logic [`PTR_W-1:0] level;
    logic              buf_empty;
    logic              buf_full;
    logic              rd_fire;
    logic              mem_we;
    logic              mem_rd_valid;

    assign level     = wr_ptr - rd_ptr;
    assign buf_empty = (level == '0);
    assign buf_full  = (level == `FULL_LEVEL);
    // drain stalls when the buffer is full, which backs up the stage
    assign stg_pop   = stg_valid && !buf_full;
    // [RULE6] gate off keeps old contents
    assign mem_we    = stg_pop && !stg_data[`DATA_W];
    // [RULE17] empty read does nothing
    assign rd_fire   = rd_req && !mbox_s && buf_path && !buf_empty;

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            wr_ptr <= '0;
        end else if (any_clear) begin
            // [RULE1] [RULE2] pointer zeroed
            wr_ptr <= '0;
        end else if (stg_pop) begin
            // [RULE6] advance regardless of gate
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            rd_ptr   <= '0;
            mark_ptr <= '0;
        end else if (any_clear) begin
            rd_ptr   <= '0;
            mark_ptr <= '0;
        end else begin
            // [RULE11] [RULE12] replay reloads pointer, reads repeat in order
            if (replay_s) begin
                rd_ptr <= mark_ptr;
            end else if (rd_fire) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            // [RULE10] location of the word on the output
            if (mark_s) begin
                mark_ptr <= shown_ptr;
            end
        end
    end

    // replay may move the read pointer behind the writer; level is the raw pointer difference, with no cap, and full is level equal to 16
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            empty_n      <= 1'b0;
            full_n       <= 1'b1;
            half_level_n <= 1'b1;
        end else if (any_clear) begin
            empty_n      <= 1'b0;
            full_n       <= 1'b1;
            half_level_n <= 1'b1;
        end else begin
            // [RULE14] active low flags
            empty_n      <= !buf_empty;
            full_n       <= !buf_full;
            // [RULE15] half occupancy
            half_level_n <= !(level >= `HALF_LEVEL);
        end
    end

    logic [`DATA_W-1:0] mem_q;

    port_memory #(
        .WIDTH (`DATA_W),
        .AW    (`BUF_AW)
    ) u_mem (
        .clk        (clk),
        .write_en   (mem_we),
        .write_addr (wr_ptr[`BUF_AW-1:0]),
        .write_data (stg_data[`DATA_W-1:0]),
        .read_en    (rd_fire),
        .read_addr  (rd_ptr[`BUF_AW-1:0]),
        .read_data  (mem_q)
    );

    // ****************************************
    // read path, mailbox and output
    // ****************************************
    logic [`DATA_W-1:0]                   mailbox;
    logic                                 mailbox_full;
    logic                                 mem_pending;
    fifo_port_control_pkg::read_source_type read_src;

    // [RULE13] mailbox bypasses the buffer sequence
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            mailbox      <= '0;
            mailbox_full <= 1'b0;
        end else if (any_clear) begin
            mailbox      <= '0;
            mailbox_full <= 1'b0;
        end else if (mbox_s && wr_req) begin
            if (!gate_sync[1]) begin
                mailbox <= din_sync;
            end
            mailbox_full <= 1'b1;
        end else if (mbox_s && rd_req) begin
            mailbox_full <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            mem_pending <= 1'b0;
            shown_ptr   <= '0;
            read_src    <= fifo_port_control_pkg::src_buffer;
        end else begin
            mem_pending <= rd_fire && !any_clear;
            if (rd_fire) begin
                shown_ptr <= rd_ptr;
            end
            // an empty mailbox read gives no valid word
            if (rd_req && mbox_s && mailbox_full) begin
                read_src <= fifo_port_control_pkg::src_mailbox;
            end else if (rd_req && !mbox_s && !buf_path) begin
                read_src <= fifo_port_control_pkg::src_config;
            end else begin
                read_src <= fifo_port_control_pkg::src_buffer;
            end
        end
    end

    assign mem_rd_valid = mem_pending;

    logic [`DATA_W-1:0] next_data_out;
    logic               next_valid;
    logic               load_out;

    always_comb begin
        next_data_out = data_out;
        next_valid    = 1'b0;
        load_out      = 1'b0;
        case (read_src)
            fifo_port_control_pkg::src_buffer: begin
                if (mem_rd_valid) begin
                    next_data_out = mem_q;
                    next_valid    = 1'b1;
                    load_out      = 1'b1;
                end
            end
            fifo_port_control_pkg::src_config: begin
                // [RULE7] config read on low byte
                next_data_out = {{(`DATA_W-`CFG_W){1'b0}}, config_reg};
                next_valid    = 1'b1;
                load_out      = 1'b1;
            end
            fifo_port_control_pkg::src_mailbox: begin
                next_data_out = mailbox;
                next_valid    = 1'b1;
                load_out      = 1'b1;
            end
            default: begin
                next_valid    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            data_out       <= '0;
            output_valid_n <= 1'b1;
        end else if (any_clear) begin
            // [RULE1] [RULE2] output register zeroed
            data_out       <= '0;
            output_valid_n <= 1'b1;
        end else begin
            if (load_out) begin
                data_out <= next_data_out;
            end
            // [RULE9] low for one cycle with a new word
            output_valid_n <= !next_valid;
        end
    end

    // [RULE8] drive pins only while output enable low
    assign data_out_en = {`DATA_W{!gate_sync[0]}};

    // ****************************************
    // checks
    // ****************************************
    sequence clear_seen;
        any_clear;
    endsequence

    clear_zero_a: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE1]
        clear_seen |=> (data_out == '0) && (wr_ptr == '0) && !empty_n)
        else $error("clear did not zero state");
    keep_cfg_a: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE2]
        part_clear && !full_clear |=> config_reg == $past(config_reg))
        else $error("partial clear changed configuration");
    mask_adv_a: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE6]
        stg_pop && !any_clear |=> wr_ptr == $past(wr_ptr) + 1'b1)
        else $error("write pointer did not advance");
    empty_hold_a: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE17]
        rd_req && buf_empty && !replay_s && !any_clear |=> rd_ptr == $past(rd_ptr))
        else $error("empty read moved pointer");
    replay_load_a: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE11]
        replay_s && !any_clear |=> rd_ptr == $past(mark_ptr))
        else $error("replay did not load mark");
    valid_read_a: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE9]
        rd_fire && !any_clear |=> ##1 !output_valid_n)
        else $error("valid strobe missing after read");
    flag_full_a: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE14]
        buf_full && !any_clear |=> !full_n)
        else $error("full flag not low");
    half_flag_a: assert property (@(posedge clk) disable iff (!rst_sync) // [RULE15]
        (level >= `HALF_LEVEL) && !any_clear |=> !half_level_n)
        else $error("half level flag not low");
endmodule
`default_nettype wire

/* dv/fifo_host_model.sv */
// host logic model driving the write and read ports of the buffer
`timescale 1ns/100ps
`default_nettype none
`include "fifo_port_control_defines.svh"
module fifo_host_model #(
    parameter logic [2:0] WIDTH_SEL = 3'h5
) (
    input  wire logic               clk,
    output logic      [2:0]         word_width_sel,
    output logic                    config_path_sel,
    output logic                    write_n,
    output logic                    input_gate_n,
    output logic      [`DATA_W-1:0] data_in,
    output logic                    read_n,
    output logic                    output_enable_n,
    output logic                    mark,
    output logic                    replay_strobe,
    output logic                    mailbox_select
);
    initial begin
        word_width_sel = WIDTH_SEL;
        config_path_sel = 1'b1;
        write_n = 1'b1;
        input_gate_n = 1'b0;
        data_in = 36'h0_0000_0000;
        read_n = 1'b1;
        output_enable_n = 1'b1;
        mark = 1'b0;
        replay_strobe = 1'b0;
        mailbox_select = 1'b0;
    end

    // back-to-back words d, d+1, ... with the strobe held low
    task automatic write_burst(input logic [`DATA_W-1:0] d, input int n, input logic gate_off);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            write_n <= 1'b0;
            input_gate_n <= gate_off;
            data_in <= d + 36'(i);
        end
        @(posedge clk);
        write_n <= 1'b1;
        // released bus shows the inverse, never a stale copy
        data_in <= ~(d + 36'(n - 1));
    endtask

    task automatic read_pulse();
        @(posedge clk);
        read_n <= 1'b0;
        @(posedge clk);
        read_n <= 1'b1;
    endtask

    task automatic pulse_mark();
        @(posedge clk);
        mark <= 1'b1;
        @(posedge clk);
        mark <= 1'b0;
    endtask

    // replay is one short high pulse
    task automatic pulse_replay();
        @(posedge clk);
        replay_strobe <= 1'b1;
        @(posedge clk);
        replay_strobe <= 1'b0;
    endtask

    task automatic set_mode(input logic buf_path, input logic mbox, input logic oe_n);
        @(posedge clk);
        config_path_sel <= buf_path;
        mailbox_select <= mbox;
        output_enable_n <= oe_n;
    endtask
endmodule
`default_nettype wire

/* dv/fifo_port_control_test.sv */
// self-checking bench for the buffer port control block
`timescale 1ns/100ps
`default_nettype none
`include "fifo_port_control_defines.svh"
module fifo_port_control_test;
    localparam logic [2:0] WSEL = 3'h5;
    logic               clk;
    logic               rst_b;
    logic               full_clear_n;
    logic               partial_clear_n;
    logic [2:0]         word_width_sel;
    logic               config_path_sel;
    logic               write_n;
    logic               input_gate_n;
    logic [`DATA_W-1:0] data_in;
    logic               read_n;
    logic               output_enable_n;
    logic               mark;
    logic               replay_strobe;
    logic               mailbox_select;
    logic [`DATA_W-1:0] data_out;
    logic [`DATA_W-1:0] data_out_en;
    logic               output_valid_n;
    logic               empty_n;
    logic               full_n;
    logic               half_level_n;
    logic [2:0]         active_width;
    logic               stage_ready;
    int                 n_fail;
    int                 total_checks;

    typedef struct packed {
        logic [`DATA_W-1:0] d;
        logic               gate_off;
        logic [`DATA_W-1:0] q;
    } row_type;
    // masked rows keep the word left there before the partial clear
    row_type rows [4] = '{
        '{36'h1_1111_1111, 1'b0, 36'h1_1111_1111},
        '{36'h2_2222_2222, 1'b1, 36'ha_0000_0001},
        '{36'h3_3333_3333, 1'b0, 36'h3_3333_3333},
        '{36'hf_ffff_ffff, 1'b1, 36'ha_0000_0003}};

    fifo_port_control dut (.clk(clk), .rst_b(rst_b), .full_clear_n(full_clear_n),
        .partial_clear_n(partial_clear_n), .word_width_sel(word_width_sel),
        .config_path_sel(config_path_sel), .write_n(write_n), .input_gate_n(input_gate_n),
        .data_in(data_in), .read_n(read_n), .output_enable_n(output_enable_n), .mark(mark),
        .replay_strobe(replay_strobe), .mailbox_select(mailbox_select), .data_out(data_out),
        .data_out_en(data_out_en), .output_valid_n(output_valid_n), .empty_n(empty_n),
        .full_n(full_n), .half_level_n(half_level_n), .active_width(active_width),
        .stage_ready(stage_ready));

    fifo_host_model #(.WIDTH_SEL(WSEL)) host (.clk(clk), .word_width_sel(word_width_sel),
        .config_path_sel(config_path_sel), .write_n(write_n), .input_gate_n(input_gate_n),
        .data_in(data_in), .read_n(read_n), .output_enable_n(output_enable_n), .mark(mark),
        .replay_strobe(replay_strobe), .mailbox_select(mailbox_select));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [`DATA_W-1:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // bounded wait; strobe syncs through two stages before the fetch
    task automatic read_expect(input logic [`DATA_W-1:0] exp);
        int k;
        host.read_pulse();
        k = 0;
        while (output_valid_n !== 1'b0 && k < 12) begin
            @(posedge clk);
            #1;
            k++;
        end
        check("valid strobe", output_valid_n, 1'b0);
        check("read data", data_out, exp);
        idle(1);
        check("valid one cycle", output_valid_n, 1'b1);
    endtask

    task automatic clear(input logic full);
        @(posedge clk);
        full_clear_n <= ~full;
        partial_clear_n <= full;
        repeat (3) @(posedge clk);
        full_clear_n <= 1'b1;
        partial_clear_n <= 1'b1;
        idle(6);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    initial begin
        logic [`DATA_W-1:0] lows;
        n_fail = 0;
        total_checks = 0;
        rst_b = 1'b0;
        full_clear_n = 1'b1;
        partial_clear_n = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check("reset data", data_out, 36'h0);
        check("reset flags", {output_valid_n, empty_n, full_n, half_level_n}, 4'hb);
        @(posedge clk);
        rst_b <= 1'b1;
        // two reset stages, two pin stages, then the echo register
        idle(6);
        check("width echo", active_width, WSEL);
        host.write_burst(36'ha_0000_0000, 4, 1'b0);
        idle(8);
        for (int i = 0; i < 4; i++) read_expect(36'ha_0000_0000 + 36'(i));
        clear(1'b0);
        check("partial clear data", data_out, 36'h0);
        check("partial clear empty", empty_n, 1'b0);
        foreach (rows[i]) host.write_burst(rows[i].d, 1, rows[i].gate_off);
        idle(8);
        foreach (rows[i]) read_expect(rows[i].q);
        // empty read must not raise the valid strobe
        host.read_pulse();
        lows = 0;
        repeat (10) begin
            idle(1);
            if (output_valid_n !== 1'b1) lows++;
        end
        check("empty read valid", lows, 36'h0);
        host.write_burst(36'hb_0000_0000, 7, 1'b0);
        idle(8);
        check("half at seven", half_level_n, 1'b1);
        host.write_burst(36'hb_0000_0007, 1, 1'b0);
        idle(8);
        check("half at eight", half_level_n, 1'b0);
        check("not full", full_n, 1'b1);
        host.write_burst(36'hb_0000_0008, 16, 1'b0);
        idle(8);
        check("full flag", full_n, 1'b0);
        check("stage refuses", stage_ready, 1'b0);
        for (int i = 0; i < 24; i++) read_expect(36'hb_0000_0000 + 36'(i));
        idle(6);
        check("drained flags", {empty_n, full_n, half_level_n}, 3'h3);
        host.write_burst(36'hc_0000_0000, 4, 1'b0);
        idle(8);
        read_expect(36'hc_0000_0000);
        host.pulse_mark();
        idle(4);
        read_expect(36'hc_0000_0001);
        read_expect(36'hc_0000_0002);
        host.pulse_replay();
        idle(4);
        for (int i = 0; i < 4; i++) read_expect(36'hc_0000_0000 + 36'(i));
        idle(4);
        check("replay ends empty", empty_n, 1'b0);
        host.set_mode(1'b1, 1'b0, 1'b0);
        idle(4);
        check("pins driven", data_out_en, {`DATA_W{1'b1}});
        host.set_mode(1'b0, 1'b0, 1'b1);
        idle(4);
        check("pins released", data_out_en, 36'h0);
        host.write_burst(36'hf_ffff_ff5a, 1, 1'b0);
        idle(8);
        read_expect(36'h0_0000_005a);
        clear(1'b0);
        read_expect(36'h0_0000_005a);
        clear(1'b1);
        read_expect(36'h0);
        host.set_mode(1'b1, 1'b1, 1'b1);
        host.write_burst(36'h5_a5a5_a5a5, 1, 1'b0);
        idle(8);
        read_expect(36'h5_a5a5_a5a5);
        check("mailbox skips buffer", empty_n, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
